// *** core/tewp_timer.sv ***
/*
  Timer core: event counting, window counting, pulse width and period
  capture, and continuous or one-shot pulse generation.
  Assumes the configuration is only changed while start control is stopped
  and the timer pin is asynchronous to clk_in.
*/
`timescale 1ns/1ps

// What this block does
// - Event mode counts each selected pin edge, rising or falling by start control.
// - Event mode match with period raises interrupt, clears counter, counting resumes.
// - Event mode compares on the edge opposite to the counting edge.
// - Auto capture copies the count each source tick in event and window modes; read after one tick.
// - Window mode counts source ticks while pin is high, or low for negative.
// - Window mode match with period raises interrupt and clears counter.
// - Pulse mode starts on trigger edge, then counts source ticks.
// - Single edge: opposite edge captures, interrupts, loads one, waits for trigger.
// - Single edge: counter rests at one after capture until next edge.
// - Double edge: capture on both edges, clear only on trigger edge.
// - Pulse generation starts on pin edge or command; one-shot bit selects form.
// - Continuous: toggle and interrupt on duty, toggle, interrupt, clear on period.
// - Start control set to stop halts counting and holds the output.
// - One-shot: period match toggles, interrupts, clears start control, stops.
// - Output pin is inverse of flip-flop; reset clears flip-flop to zero.
module tewp_timer (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // Configuration
  input  wire tewp_pkg::tewp_cfg_t  cfg_in,
  input  wire logic [1:0]           start_control_in,
  input  wire logic                 start_write_in,
  input  wire logic [15:0]          period_compare_in,
  input  wire logic [15:0]          duty_value_in,
  // Pin side
  input  wire logic                 timer_input_pin_in,
  output logic                      pulse_output_pin_out,
  // Status
  output logic [1:0]                start_control_out,
  output logic [15:0]               capture_value_out,
  output logic [15:0]               count_out,
  output logic                      timer_match_irq_out
);

  logic [2:0]  pin_sync_reg;
  logic        pin_level;
  logic        pin_rise;
  logic        pin_fall;
  logic [10:0] div_reg;
  logic [10:0] div_mask;
  logic        tick;
  logic [1:0]  start_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cap_reg;
  logic        irq_reg;
  logic        pin_out_reg;
  logic        pm_run_reg;
  logic        ppg_run_reg;
  logic        running;
  logic        trig_edge;
  logic        opp_edge;
  logic        cnt_edge_pos;
  logic        mode_ppg;
  tewp_pkg::tewp_mode_t mode;

  assign mode         = cfg_in.mode_select;
  assign mode_ppg     = (mode == tewp_pkg::TEWP_MODE_PPG);
  assign running      = (start_reg != tewp_pkg::START_STOP);
  assign cnt_edge_pos = (start_reg != tewp_pkg::START_FALLING);
  assign pin_level    = pin_sync_reg[2];
  // Edge flagged while stage two holds the new level and stage three the old
  assign pin_rise     = pin_sync_reg[1] & ~pin_sync_reg[2];
  assign pin_fall     = ~pin_sync_reg[1] & pin_sync_reg[2];
  assign trig_edge    = cnt_edge_pos ? pin_rise : pin_fall;
  assign opp_edge     = cnt_edge_pos ? pin_fall : pin_rise;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pin_sync_reg <= 3'h0;
    else
      pin_sync_reg <= {pin_sync_reg[1:0], timer_input_pin_in};
  end

  always_comb
  begin
    unique case (cfg_in.source_clock_select)
      2'h0: div_mask = tewp_pkg::DIV_MASK_SLOW;
      2'h1: div_mask = tewp_pkg::DIV_MASK_MID;
      2'h2: div_mask = tewp_pkg::DIV_MASK_FAST;
      2'h3: div_mask = tewp_pkg::DIV_MASK_FULL;
    endcase
  end

  assign tick = ((div_reg & div_mask) == div_mask);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      div_reg <= 11'h000;
    else
      div_reg <= div_reg + 11'h001;
  end

  // Start control: software writes, one-shot completion clears it
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      start_reg <= tewp_pkg::START_STOP;
    else if (start_write_in)
      start_reg <= start_control_in;
    else if (mode_ppg && ppg_run_reg && tick && cfg_in.oneshot_select &&
             cnt_reg == period_compare_in)
      start_reg <= tewp_pkg::START_STOP;
  end

  // Pulse measurement arms on the trigger edge; pulse generation on it or on command start
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pm_run_reg <= 1'b0;
    else if (!running || mode != tewp_pkg::TEWP_MODE_PULSE)
      pm_run_reg <= 1'b0;
    else if (trig_edge)
      pm_run_reg <= 1'b1;
    else if (opp_edge && cfg_in.capture_edge_mode)
      pm_run_reg <= 1'b0;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ppg_run_reg <= 1'b0;
    else if (!running || !mode_ppg)
      ppg_run_reg <= 1'b0;
    else if (start_reg == tewp_pkg::START_CMD || trig_edge)
      ppg_run_reg <= 1'b1;
  end

  // Up-counter
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_reg <= tewp_pkg::CNT_ZERO;
    else if (!running && !mode_ppg)
      cnt_reg <= tewp_pkg::CNT_ZERO;
    else if (running)
    begin
      unique case (mode)
        tewp_pkg::TEWP_MODE_EVENT:
        begin
          if (opp_edge && cnt_reg == period_compare_in)
            cnt_reg <= tewp_pkg::CNT_ZERO;
          else if (trig_edge)
            cnt_reg <= cnt_reg + tewp_pkg::CNT_ONE;
        end
        tewp_pkg::TEWP_MODE_WINDOW:
        begin
          // Gate level must equal the chosen polarity at the tick
          if (tick && (pin_level == cnt_edge_pos))
          begin
            if (cnt_reg == period_compare_in)
              cnt_reg <= tewp_pkg::CNT_ZERO;
            else
              cnt_reg <= cnt_reg + tewp_pkg::CNT_ONE;
          end
        end
        tewp_pkg::TEWP_MODE_PULSE:
        begin
          if (cfg_in.capture_edge_mode && opp_edge && pm_run_reg)
            cnt_reg <= tewp_pkg::CNT_ONE;
          else if (!cfg_in.capture_edge_mode && trig_edge)
            cnt_reg <= tewp_pkg::CNT_ZERO;
          else if (pm_run_reg && tick)
            cnt_reg <= cnt_reg + tewp_pkg::CNT_ONE;
        end
        tewp_pkg::TEWP_MODE_PPG:
        begin
          if (ppg_run_reg && tick)
          begin
            if (cnt_reg == period_compare_in)
              cnt_reg <= tewp_pkg::CNT_ZERO;
            else
              cnt_reg <= cnt_reg + tewp_pkg::CNT_ONE;
          end
        end
        default:
          cnt_reg <= cnt_reg;
      endcase
    end
  end

  // Capture register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cap_reg <= tewp_pkg::CNT_ZERO;
    else if (running && mode == tewp_pkg::TEWP_MODE_PULSE && pm_run_reg &&
             (opp_edge || (trig_edge && !cfg_in.capture_edge_mode)))
      cap_reg <= cnt_reg;
    else if (running && cfg_in.auto_capture_enable && tick &&
             (mode == tewp_pkg::TEWP_MODE_EVENT ||
              mode == tewp_pkg::TEWP_MODE_WINDOW))
      cap_reg <= cnt_reg;
  end

  // Interrupt pulse
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_reg <= 1'b0;
    else if (!running)
      irq_reg <= 1'b0;
    else
    begin
      unique case (mode)
        tewp_pkg::TEWP_MODE_EVENT:
          irq_reg <= opp_edge && cnt_reg == period_compare_in;
        tewp_pkg::TEWP_MODE_WINDOW:
          irq_reg <= tick && (pin_level == cnt_edge_pos) &&
                     cnt_reg == period_compare_in;
        tewp_pkg::TEWP_MODE_PULSE:
          irq_reg <= pm_run_reg && (opp_edge ||
                     (trig_edge && !cfg_in.capture_edge_mode));
        tewp_pkg::TEWP_MODE_PPG:
          irq_reg <= ppg_run_reg && tick &&
                     (cnt_reg == duty_value_in ||
                      cnt_reg == period_compare_in);
        default:
          irq_reg <= 1'b0;
      endcase
    end
  end

  // Pin level is the inverse of the output flip-flop; outside pulse generation mode
  // the flip-flop tracks its init bit so re-entering pulse generation reloads it
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pin_out_reg <= 1'b1;
    else if (!mode_ppg || (!running && !ppg_run_reg &&
             cnt_reg == tewp_pkg::CNT_ZERO && start_write_in))
      pin_out_reg <= ~cfg_in.output_ff_init;
    // Gated by running so the cycle after a stop cannot still toggle
    else if (running && ppg_run_reg && tick &&
             (cnt_reg == duty_value_in || cnt_reg == period_compare_in))
      pin_out_reg <= ~pin_out_reg;
  end

  assign pulse_output_pin_out = pin_out_reg;
  assign start_control_out    = start_reg;
  assign capture_value_out    = cap_reg;
  assign count_out            = cnt_reg;
  assign timer_match_irq_out  = irq_reg;

  sequence event_match_s;
    mode == tewp_pkg::TEWP_MODE_EVENT && running && opp_edge &&
    cnt_reg == period_compare_in;
  endsequence

  // Stopped in pulse generation with no write that could reload the output
  sequence ppg_idle_s;
    mode_ppg && !running && !start_write_in;
  endsequence

  event_irq_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    event_match_s |=> irq_reg && cnt_reg == tewp_pkg::CNT_ZERO)
    else $error("event match did not interrupt and clear");

  event_count_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    mode == tewp_pkg::TEWP_MODE_EVENT && running && trig_edge &&
    !start_write_in |=> cnt_reg == $past(cnt_reg) + tewp_pkg::CNT_ONE)
    else $error("event edge not counted");

  event_quiet_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    mode == tewp_pkg::TEWP_MODE_EVENT && running && !opp_edge |=> !irq_reg)
    else $error("event interrupt off the opposite edge");

  window_gate_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    mode == tewp_pkg::TEWP_MODE_WINDOW && running && !start_write_in &&
    pin_level != cnt_edge_pos |=> $stable(cnt_reg))
    else $error("window counted outside the gate");

  single_rest_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    mode == tewp_pkg::TEWP_MODE_PULSE && running && pm_run_reg &&
    cfg_in.capture_edge_mode && opp_edge && !start_write_in
    |=> cnt_reg == tewp_pkg::CNT_ONE && cap_reg == $past(cnt_reg) &&
        irq_reg)
    else $error("single edge capture failed");

  ppg_toggle_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    mode_ppg && running && ppg_run_reg && tick &&
    cnt_reg == period_compare_in
    |=> pulse_output_pin_out != $past(pulse_output_pin_out) && irq_reg)
    else $error("period match did not toggle output");

  ppg_hold_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    ppg_idle_s |=> $stable(pulse_output_pin_out) && $stable(cnt_reg))
    else $error("stopped output moved");

  oneshot_stop_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    mode_ppg && ppg_run_reg && tick && cfg_in.oneshot_select &&
    cnt_reg == period_compare_in && !start_write_in
    |=> start_control_out == tewp_pkg::START_STOP ##1 !ppg_run_reg)
    else $error("one-shot did not stop");

  init_level_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    !mode_ppg |=> pulse_output_pin_out == ~$past(cfg_in.output_ff_init))
    else $error("output not inverse of init");

endmodule : tewp_timer

// *** shared/tewp_pkg.sv ***
/*
  Constants, encodings and the configuration carrier for the sixteen-bit
  event, window, pulse measurement and pulse generation timer.
  Assumes a single 10 MHz system clock feeding every consumer.
*/
package tewp_pkg;

  localparam int unsigned CNT_W = 16;

  // Start control encodings
  localparam logic [1:0] START_STOP    = 2'h0;
  localparam logic [1:0] START_CMD     = 2'h1;
  localparam logic [1:0] START_RISING  = 2'h2;
  localparam logic [1:0] START_FALLING = 2'h3;

  // Source clock dividers: the enable fires when the low bits are all ones
  localparam int unsigned DIV_W          = 11;
  localparam logic [10:0] DIV_MASK_SLOW  = 11'h7ff;
  localparam logic [10:0] DIV_MASK_MID   = 11'h07f;
  localparam logic [10:0] DIV_MASK_FAST  = 11'h00f;
  localparam logic [10:0] DIV_MASK_FULL  = 11'h001;

  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

  typedef enum logic [2:0] {
    TEWP_MODE_TIMER  = 3'b000,
    TEWP_MODE_EVENT  = 3'b001,
    TEWP_MODE_WINDOW = 3'b010,
    TEWP_MODE_PULSE  = 3'b011,
    TEWP_MODE_PPG    = 3'b100
  } tewp_mode_t;

  typedef struct packed {
    tewp_mode_t  mode_select;
    logic [1:0]  source_clock_select;
    logic        auto_capture_enable;
    logic        capture_edge_mode;
    logic        oneshot_select;
    logic        output_ff_init;
  } tewp_cfg_t;

endpackage : tewp_pkg

// *** verif/tewp_pin_model.sv ***
/*
  Pin-side partner: pulse source on the timer input, and a load that
  stamps the cycle of every change on the pulse output.
  Assumes its tasks are entered just after a rising clk_in edge.
*/
`timescale 1ns/1ps
module tewp_pin_model (
  // Clock
  input  wire logic clk_in,
  // Pins
  input  wire logic pulse_pin_in,
  output logic      pin_out
);
  int unsigned cyc  = 0;
  int unsigned tog[$];
  logic        last = 1'b1;

  initial pin_out = 1'b0;

  always @(posedge clk_in)
  begin
    cyc  <= cyc + 1;
    last <= pulse_pin_in;
    if (pulse_pin_in !== last)
      tog.push_back(cyc);
  end

  task automatic idle(input logic lvl);
    pin_out <= lvl;
  endtask : idle

  // Callers keep both levels well above two cycles
  task automatic pulse(input logic lvl, input int h, input int l);
    pin_out <= lvl;
    repeat (h) @(posedge clk_in);
    pin_out <= ~lvl;
    repeat (l) @(posedge clk_in);
  endtask : pulse
endmodule : tewp_pin_model

// *** verif/test_timer_event_window_pwm_ppg.sv ***
/*
  Self-checking bench for the timer core with a pin-side partner.
  Assumes the design files and package are compiled first.
*/
`timescale 1ns/1ps
module test_timer_event_window_pwm_ppg;
  logic                clk_in = 1'b0;
  logic                rst_in = 1'b1;
  logic                st_wr  = 1'b0;
  logic [1:0]          st_val = 2'h0;
  logic [15:0]         per    = 16'hffff;
  logic [15:0]         duty   = 16'h0000;
  tewp_pkg::tewp_cfg_t cfg    = '0;
  logic                pin, pout, irq, p1;
  logic [1:0]          st_out;
  logic [15:0]         cap, cnt, c1;
  logic [15:0]         caps[$];
  int                  n_errors = 0, num_checks = 0, n_irq = 0, e, ei;

  initial forever #50 clk_in = ~clk_in;

  tewp_timer i_tewp_timer (.clk_in(clk_in), .rst_in(rst_in), .cfg_in(cfg),
    .start_control_in(st_val), .start_write_in(st_wr),
    .period_compare_in(per), .duty_value_in(duty),
    .timer_input_pin_in(pin), .pulse_output_pin_out(pout),
    .start_control_out(st_out), .capture_value_out(cap), .count_out(cnt),
    .timer_match_irq_out(irq));
  tewp_pin_model i_tewp_pin_model (.clk_in(clk_in), .pulse_pin_in(pout),
    .pin_out(pin));

  // Capture taken with its interrupt, before the next trigger
  always @(posedge clk_in)
    if (irq === 1'b1)
    begin
      n_irq <= n_irq + 1;
      caps.push_back(cap);
    end

  task automatic check(input logic [15:0] s, input logic [15:0] x);
    num_checks++;
    if (s !== x)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  task automatic wr(input logic [1:0] v);
    st_val <= v;
    st_wr  <= 1'b1;
    tick(1);
    st_wr  <= 1'b0;
    tick(1);
  endtask : wr

  function automatic tewp_pkg::tewp_cfg_t cf(input logic [2:0] m,
                                             input logic [5:0] b);
    return tewp_pkg::tewp_cfg_t'({m, b});
  endfunction : cf

  // Reset between tests so the timer core starts from a known count
  task automatic restart(input tewp_pkg::tewp_cfg_t c, input logic lvl);
    rst_in <= 1'b1;
    cfg    <= c;
    i_tewp_pin_model.idle(lvl);
    tick(7);
    // Cleared late: reset moves the output pin and the load stamps it
    n_irq = 0;
    caps.delete();
    i_tewp_pin_model.tog.delete();
    tick(1);
    rst_in <= 1'b0;
    tick(1);
  endtask : restart

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial
  begin
    #5_000_000;
    n_errors++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'h964a16a1));
    restart(cf(tewp_pkg::TEWP_MODE_TIMER, 6'h00), 1'b0);
    check({12'h000, pout, st_out, irq}, 16'h0008);
    check(cap | cnt, 16'h0000);
    $display("reset test done");
    for (int ed = 0; ed < 2; ed++)
    begin
      restart(cf(tewp_pkg::TEWP_MODE_EVENT, 6'h38), ed[0]);
      per <= 16'(3 + $urandom % 4);
      wr(2'(2 + ed));
      e  = 0;
      ei = 0;
      repeat (10)
      begin
        i_tewp_pin_model.pulse(~ed[0], 4 + $urandom % 4, 6 + $urandom % 4);
        e++;
        if (e == int'(per))
        begin
          e = 0;
          ei++;
        end
        check(cnt, 16'(e));
        check(16'(n_irq), 16'(ei));
        check(cap, 16'(e));
      end
    end
    $display("event test done");
    for (int ed = 0; ed < 2; ed++)
    begin
      restart(cf(tewp_pkg::TEWP_MODE_WINDOW, 6'h30), ed[0]);
      per <= 16'h0004;
      wr(2'(2 + ed));
      tick(30);
      check(cnt, 16'h0000);
      i_tewp_pin_model.pulse(~ed[0], 40, 10);
      check({15'h0000, cnt <= 16'h0004 && n_irq inside {[3:5]}},
            16'h0001);
      c1 = cnt;
      tick(30);
      check(cnt, c1);
    end
    $display("window test done");
    restart(cf(tewp_pkg::TEWP_MODE_PULSE, 6'h34), 1'b0);
    wr(2'h2);
    repeat (3) i_tewp_pin_model.pulse(1'b1, 20, 20);
    check(16'(n_irq), 16'h0003);
    check(caps[2], caps[1]);
    check(caps[1], caps[0] + 16'h0001);
    check({15'h0000, caps[1] inside {[10:12]}}, 16'h0001);
    restart(cf(tewp_pkg::TEWP_MODE_PULSE, 6'h30), 1'b0);
    wr(2'h2);
    repeat (3) i_tewp_pin_model.pulse(1'b1, 20, 40);
    check(16'(n_irq), 16'h0005);
    check({15'h0000, caps[2] inside {[9:11]}}, 16'h0001);
    check({15'h0000, caps[3] inside {[28:32]}}, 16'h0001);
    $display("pulse measure test done");
    restart(cf(tewp_pkg::TEWP_MODE_PPG, 6'h30), 1'b0);
    per  <= 16'h000a;
    duty <= 16'h0004;
    tick(1);
    check({15'h0000, pout}, 16'h0001);
    wr(2'h1);
    tick(70);
    check(16'(i_tewp_pin_model.tog[1] - i_tewp_pin_model.tog[0]),
          16'h000c);
    check(16'(i_tewp_pin_model.tog[2] - i_tewp_pin_model.tog[1]),
          16'h000a);
    check(16'(n_irq), 16'(i_tewp_pin_model.tog.size()));
    wr(2'h0);
    p1 = pout;
    c1 = cnt;
    tick(30);
    check({15'h0000, pout}, {15'h0000, p1});
    check(cnt, c1);
    restart(cf(tewp_pkg::TEWP_MODE_PPG, 6'h30), 1'b0);
    wr(2'h2);
    tick(30);
    check(cnt, 16'h0000);
    i_tewp_pin_model.pulse(1'b1, 4, 10);
    check({15'h0000, cnt != 16'h0000}, 16'h0001);
    for (int i = 0; i < 2; i++)
    begin
      restart(cf(tewp_pkg::TEWP_MODE_PPG, {5'b11001, i[0]}), 1'b0);
      wr(2'h1);
      check({15'h0000, pout}, {15'h0000, ~i[0]});
      tick(40);
      check({14'h0000, st_out}, 16'h0000);
      check({15'h0000, pout}, {15'h0000, ~i[0]});
      check(16'(n_irq), 16'h0002);
      check(16'(i_tewp_pin_model.tog.size()), 16'(2 + i));
    end
    $display("pulse generation test done");
    end_sim();
  end
endmodule : test_timer_event_window_pwm_ppg
